// File: apec_pkg.sv
/*
  apec_pkg: constants and carrier types for the ata port enable control.
  assumes a 200 MHz core clock; all timing counts derive from it.
*/
package apec_pkg;

  localparam int unsigned CLK_MHZ        = 200;
  localparam int unsigned PWRUP_DELAY_US = 2000;
  localparam int unsigned POLL_PERIOD_US = 20000;
  localparam int unsigned PWRUP_CYCLES   = PWRUP_DELAY_US * CLK_MHZ;
  localparam int unsigned POLL_CYCLES    = POLL_PERIOD_US * CLK_MHZ;
  localparam int unsigned CNT_W          = 23;

  localparam logic [2:0] ADDR_IDLE       = 3'h7;
  localparam logic [1:0] CS_IDLE_N       = 2'h3;
  localparam logic       STROBE_IDLE_N   = 1'b1;

  typedef enum logic [1:0] {
    APEC_ST_BOOT    = 2'b00,
    APEC_ST_RUN     = 2'b01,
    APEC_ST_PARKED  = 2'b10
  } apec_state_t;

  // ata outputs as driven by the transfer engine or by this block
  typedef struct packed {
    logic [2:0] addr;
    logic [1:0] cs_n;
    logic       rd_n;
    logic       wr_n;
    logic       dmack_n;
    logic       drive_reset_out_n;
  } apec_ata_out_t;

  localparam apec_ata_out_t ATA_IDLE = '{
    addr: ADDR_IDLE, cs_n: CS_IDLE_N, rd_n: STROBE_IDLE_N,
    wr_n: STROBE_IDLE_N, dmack_n: STROBE_IDLE_N,
    drive_reset_out_n: 1'b1};

endpackage : apec_pkg

// File: apec_sync.sv
/*
  apec_sync: three-flop synchroniser with agreement filter for a pin.
  assumes the pin is asynchronous to core_clk.
*/
`timescale 1ns/1ps
module apec_sync (
  input  wire logic core_clk,
  input  wire logic rstn,
  input  wire logic pin_in,
  output logic      level_out
);
  logic s1_r;
  logic s2_r;
  logic s3_r;

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // level only moves once the last two stages agree
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      level_out <= 1'b0;
    end else if (s2_r == s3_r) begin
      level_out <= s3_r;
    end
  end
endmodule : apec_sync

// File: apec_top.sv
/*
  apec_top: start-up pin states and enable gating for the ata host port.
  assumes the ata transfer engine drives eng_out and honours eng_run;
  pad logic builds each wire from the value and its output enable.
*/
`timescale 1ns/1ps
module apec_top #(
  parameter int unsigned PWRUP_CYC = apec_pkg::PWRUP_CYCLES,
  parameter int unsigned POLL_CYC  = apec_pkg::POLL_CYCLES
) (
  input  wire logic              core_clk,
  input  wire logic              rstn,
  input  wire logic              ata_port_enable,
  input  wire logic              bus_power_present,
  input  wire logic              mfg_test_mode,
  input  apec_pkg::apec_ata_out_t eng_out,
  output apec_pkg::apec_ata_out_t ata_out,
  output logic                   ata_out_oe,
  output logic                   eng_run,
  output logic                   eng_restart,
  output logic                   usb_connect,
  output logic                   bus_power_seen
);
  logic [apec_pkg::CNT_W-1:0] boot_cnt_r;
  logic [apec_pkg::CNT_W-1:0] poll_cnt_r;
  apec_pkg::apec_state_t      state_r;
  apec_pkg::apec_state_t      state_nxt;
  logic                       en_sync;
  logic                       pwr_sync;
  logic                       sample_r;
  logic                       poll_tick;
  logic                       fall_seen;
  logic                       rise_seen;

  function automatic logic [apec_pkg::CNT_W-1:0] cnt_last(
    input int unsigned cyc);
    cnt_last = apec_pkg::CNT_W'(cyc - 1);
  endfunction : cnt_last

  apec_sync u_en_sync (
    .core_clk  (core_clk),
    .rstn      (rstn),
    .pin_in    (ata_port_enable),
    .level_out (en_sync)
  );

  apec_sync u_pwr_sync (
    .core_clk  (core_clk),
    .rstn      (rstn),
    .pin_in    (bus_power_present),
    .level_out (pwr_sync)
  );

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      bus_power_seen <= 1'b0;
    end else begin
      bus_power_seen <= pwr_sync;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      boot_cnt_r <= '0;
    end else if (state_r == apec_pkg::APEC_ST_BOOT) begin
      boot_cnt_r <= boot_cnt_r + 1'b1;
    end
  end

  // poll period counter, idle in test mode
  always_ff @(posedge core_clk) begin
    if (!rstn || state_r == apec_pkg::APEC_ST_BOOT || mfg_test_mode) begin
      poll_cnt_r <= '0;
    end else if (poll_tick) begin
      poll_cnt_r <= '0;
    end else begin
      poll_cnt_r <= poll_cnt_r + 1'b1;
    end
  end

  assign poll_tick = !mfg_test_mode &&
                     state_r != apec_pkg::APEC_ST_BOOT &&
                     poll_cnt_r == cnt_last(POLL_CYC);

  // previous sample kept; pin is expected high at start-up
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      sample_r <= 1'b1;
    end else if (poll_tick) begin
      sample_r <= en_sync;
    end
  end

  // act only on a changed sample
  assign fall_seen = poll_tick && sample_r && !en_sync;
  assign rise_seen = poll_tick && !sample_r && en_sync;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      apec_pkg::APEC_ST_BOOT: begin
        if (boot_cnt_r == cnt_last(PWRUP_CYC)) begin
          state_nxt = apec_pkg::APEC_ST_RUN;
        end
      end
      apec_pkg::APEC_ST_RUN: begin
        if (fall_seen) begin
          state_nxt = apec_pkg::APEC_ST_PARKED;
        end
      end
      apec_pkg::APEC_ST_PARKED: begin
        if (rise_seen) begin
          state_nxt = apec_pkg::APEC_ST_RUN;
        end
      end
      default: begin
        state_nxt = apec_pkg::APEC_ST_BOOT;
      end
    endcase
  end

  // chip reset returns everything to boot
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      state_r <= apec_pkg::APEC_ST_BOOT;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      eng_run     <= 1'b0;
      eng_restart <= 1'b0;
      usb_connect <= 1'b0;
    end else begin
      eng_run     <= state_nxt == apec_pkg::APEC_ST_RUN;
      eng_restart <= state_r == apec_pkg::APEC_ST_PARKED && rise_seen;
      usb_connect <= state_nxt == apec_pkg::APEC_ST_RUN;
    end
  end

  // idle high in boot, engine values while running
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      ata_out <= apec_pkg::ATA_IDLE;
    end else if (state_nxt == apec_pkg::APEC_ST_RUN) begin
      ata_out <= eng_out;
    end else begin
      ata_out <= apec_pkg::ATA_IDLE;
    end
  end

  // no drive in boot or while parked
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      ata_out_oe <= 1'b0;
    end else begin
      ata_out_oe <= state_nxt == apec_pkg::APEC_ST_RUN;
    end
  end

  boot_quiet_a: assert property (@(posedge core_clk) disable iff (!rstn)
    state_r == apec_pkg::APEC_ST_BOOT && boot_cnt_r != cnt_last(PWRUP_CYC)
    |=> !ata_out_oe)
    else $error("ata drive during start-up delay");

  boot_exit_a: assert property (@(posedge core_clk) disable iff (!rstn)
    $rose(ata_out_oe) && $past(state_r) == apec_pkg::APEC_ST_BOOT
    |-> $past(boot_cnt_r) == cnt_last(PWRUP_CYC))
    else $error("start-up delay length wrong");

  poll_mfg_a: assert property (@(posedge core_clk) disable iff (!rstn)
    mfg_test_mode |-> !poll_tick)
    else $error("poll in test mode");

  poll_space_a: assert property (@(posedge core_clk) disable iff (!rstn)
    poll_tick |=> !poll_tick [*2])
    else $error("polls too close");

  park_hiz_a: assert property (@(posedge core_clk) disable iff (!rstn)
    fall_seen && state_r == apec_pkg::APEC_ST_RUN
    |=> !ata_out_oe && !eng_run && !usb_connect)
    else $error("port not parked on low enable");

  park_hold_a: assert property (@(posedge core_clk) disable iff (!rstn)
    state_r == apec_pkg::APEC_ST_PARKED && !rise_seen |=> !eng_run)
    else $error("engine ran while parked");

  resume_a: assert property (@(posedge core_clk) disable iff (!rstn)
    rise_seen && state_r == apec_pkg::APEC_ST_PARKED
    |=> eng_restart && usb_connect && ata_out_oe)
    else $error("no resume on rising enable");

  change_only_a: assert property (@(posedge core_clk)
    disable iff (!rstn)
    poll_tick && en_sync == sample_r |=> state_r == $past(state_r))
    else $error("state moved without change");

  reset_boot_a: assert property (@(posedge core_clk)
    !rstn |=> state_r == apec_pkg::APEC_ST_BOOT && !ata_out_oe)
    else $error("reset did not clear state");

  run_c: cover property (@(posedge core_clk) disable iff (!rstn)
    $rose(eng_run));
  park_c: cover property (@(posedge core_clk) disable iff (!rstn)
    fall_seen && state_r == apec_pkg::APEC_ST_RUN);
  resume_c: cover property (@(posedge core_clk) disable iff (!rstn)
    eng_restart);
endmodule : apec_top

// File: apec_disk_model.sv
/*
  apec_disk_model: ata device side of the port, resolving each pin.
  assumes ata_out and ata_out_oe come straight from apec_top.
*/
`timescale 1ns/1ps
module apec_disk_model (
  input  apec_pkg::apec_ata_out_t ata_out,
  input  wire logic               ata_out_oe,
  output apec_pkg::apec_ata_out_t pin_lvl
);
  assign pin_lvl = ata_out_oe ? ata_out : apec_pkg::apec_ata_out_t'(10'bz);
endmodule : apec_disk_model

// File: apec_top_test.sv
/*
  apec_top_test: random engine traffic, enable polling, test mode, reset.
  assumes short counts (boot 20, poll 50) and a 1-cycle pin register.
*/
`timescale 1ns/1ps
module apec_top_test;
  localparam int unsigned PW = 20;
  localparam int unsigned PL = 50;
  logic                    core_clk, rstn, en, vbus, tmode;
  logic                    oe, run, restart, conn, seen;
  apec_pkg::apec_ata_out_t eng_out, eng_prev, ata_out, pin_lvl;
  logic [31:0]             seed = 32'h0001_814A;
  int                      mismatches, comparisons, cyc, n, t0;

  apec_top #(.PWRUP_CYC(PW), .POLL_CYC(PL)) i_dut (
    .core_clk(core_clk), .rstn(rstn), .ata_port_enable(en),
    .bus_power_present(vbus), .mfg_test_mode(tmode), .eng_out(eng_out),
    .ata_out(ata_out), .ata_out_oe(oe), .eng_run(run),
    .eng_restart(restart), .usb_connect(conn), .bus_power_seen(seen));
  apec_disk_model i_disk (.ata_out(ata_out), .ata_out_oe(oe),
    .pin_lvl(pin_lvl));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs

  function automatic apec_pkg::apec_ata_out_t exp_pins(input logic up,
      input apec_pkg::apec_ata_out_t e);
    return up ? e : apec_pkg::ATA_IDLE;
  endfunction : exp_pins

  task automatic finish_test();
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : finish_test

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    seed <= xs(seed);
    eng_out <= apec_pkg::apec_ata_out_t'(seed[9:0]);
    eng_prev <= eng_out;
    cyc <= cyc + 1;
    if (cyc > 2000) begin
      mismatches++;
      finish_test();
    end
  end

  task automatic tick(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask : tick

  task automatic chk_flag(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %0t flag %b not %b", $time, got, exp);
    end
  endtask : chk_flag

  task automatic chk_pins(input apec_pkg::apec_ata_out_t got, exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %0t pins %b not %b", $time, got, exp);
    end
  endtask : chk_pins

  task automatic chk_time(input int got, lo, hi);
    comparisons++;
    if (got < lo || got > hi) begin
      mismatches++;
      $display("mismatch %0t delay %0d", $time, got);
    end
  endtask : chk_time

  task automatic wait_oe(input logic v);
    n = 0;
    while (oe !== v && n < 300) begin
      tick(1);
      n++;
    end
  endtask : wait_oe

  task automatic check_up(input logic up);
    chk_flag(oe, up);
    chk_flag(run, up);
    chk_flag(conn, up);
    chk_pins(ata_out, exp_pins(up, eng_prev));
    chk_pins(pin_lvl, up ? eng_prev : apec_pkg::apec_ata_out_t'(10'bz));
  endtask : check_up

  initial begin
    rstn = 1'b0;
    en = 1'b1;
    vbus = 1'b0;
    tmode = 1'b0;
    tick(3);
    check_up(1'b0);
    @(posedge core_clk) rstn <= 1'b1;
    wait_oe(1'b1);
    t0 = cyc;
    chk_time(n, PW - 2, PW + 2);
    check_up(1'b1);
    // bus power present comes from the system side
    @(posedge core_clk) vbus <= 1'b1;
    tick(8);
    chk_flag(seen, 1'b1);
    @(posedge core_clk) en <= 1'b0;
    wait_oe(1'b0);
    chk_time((cyc - t0 + 2) % PL, 0, 4);
    check_up(1'b0);
    // short high pulse between polls must be missed
    tick(10);
    @(posedge core_clk) en <= 1'b1;
    tick(3);
    @(posedge core_clk) en <= 1'b0;
    tick(PL);
    check_up(1'b0);
    @(posedge core_clk) en <= 1'b1;
    wait_oe(1'b1);
    chk_time((cyc - t0 + 2) % PL, 0, 4);
    chk_flag(restart, 1'b1);
    tick(1);
    chk_flag(restart, 1'b0);
    repeat (20) begin
      tick(1);
      check_up(1'b1);
    end
    @(posedge core_clk) tmode <= 1'b1;
    @(posedge core_clk) en <= 1'b0;
    tick(3 * PL);
    check_up(1'b1);
    @(posedge core_clk) tmode <= 1'b0;
    wait_oe(1'b0);
    chk_time(n, 1, PL + 4);
    @(posedge core_clk) en <= 1'b1;
    @(posedge core_clk) rstn <= 1'b0;
    tick(4);
    check_up(1'b0);
    @(posedge core_clk) rstn <= 1'b1;
    wait_oe(1'b1);
    chk_time(n, PW - 2, PW + 2);
    @(posedge core_clk) vbus <= 1'b0;
    tick(8);
    chk_flag(seen, 1'b0);
    finish_test();
  end
endmodule : apec_top_test
